// [hw/core_mem_pkg.sv]
// Shared constants and types for the core memory and reset block
package core_mem_pkg;

  // ----------------------------------------
  // Special function register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_FIRST_LOW = 8'h82;
  localparam logic [7:0] ADDR_FIRST_HIGH = 8'h83;
  localparam logic [7:0] ADDR_SECOND_LOW = 8'h84;
  localparam logic [7:0] ADDR_SECOND_HIGH = 8'h85;
  localparam logic [7:0] ADDR_POINTER_SELECT = 8'h86;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8E;
  localparam logic [7:0] ADDR_EXTERNAL_PAGE = 8'h92;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'hD0;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'hE0;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int BANK_LSB = 3;
  localparam int BANK_MSB = 4;
  localparam int STRETCH_MSB = 2;
  localparam logic [7:0] STACK_POINTER_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h01;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ----------------------------------------
  // Sizes and timing counts
  // ----------------------------------------
  localparam int IRAM_BYTES = 128;
  localparam int XRAM_BYTES = 2048;
  localparam int XRAM_AW = 11;
  localparam logic [3:0] CYCLE_CLOCKS = 4'h4;
  localparam logic [10:0] HOLD_CYCLES = 11'h400;

  // ----------------------------------------
  // Access sequencer states, Gray along the path
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH = 3'h1,
    ST_ADDR = 3'h3,
    ST_WAIT = 3'h2,
    ST_LAST = 3'h6
  } access_state_t;

  // ----------------------------------------
  // Memory operations
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_DIR_RD = 4'h0,
    OP_DIR_WR = 4'h1,
    OP_IND_RD = 4'h2,
    OP_IND_WR = 4'h3,
    OP_REG_RD = 4'h4,
    OP_REG_WR = 4'h5,
    OP_XDP_RD = 4'h6,
    OP_XDP_WR = 4'h7,
    OP_XRI_RD = 4'h8,
    OP_XRI_WR = 4'h9,
    OP_CODE_DP = 4'hA,
    OP_CODE_PC = 4'hB,
    OP_PUSH = 4'hC,
    OP_POP = 4'hD,
    OP_TRAP = 4'hE
  } mem_op_t;

  typedef struct packed {
    mem_op_t op;
    logic [15:0] addr;
    logic [2:0] rn;
    logic [7:0] data;
  } mem_req_t;

  typedef struct packed {
    logic done;
    logic trap;
    logic [7:0] rdata;
  } mem_rsp_t;

endpackage : core_mem_pkg

// [hw/core_reset_gen.sv]
// Reset synchroniser and hold-off stretcher for the core
module core_reset_gen (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic por_req,
  input wire logic bod_req,
  input wire logic wdt_req,
  input wire logic adc_req,
  output logic core_rst_b
);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [1:0] pin_sync; // Pin release passes two stages
  logic [3:0] req_meta; // First stage of source requests
  logic [3:0] req_sync; // Second stage, safe to use
  logic [10:0] hold_cnt; // Clocks of hold-off still owed
  wire hold_src = req_sync[0] | req_sync[3];
  wire any_src = |req_sync;

  // Pin reset asserts at once, releases after two edges
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_sync <= 2'h0;
    end else begin
      pin_sync <= {pin_sync[0], 1'b1};
    end
  end

  // Requests from other blocks arrive on unrelated timing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      req_meta <= 4'h0;
      req_sync <= 4'h0;
    end else begin
      req_meta <= {adc_req, wdt_req, bod_req, por_req};
      req_sync <= req_meta;
    end
  end

  // Power-on and converter resets keep the core held after release
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt <= 11'h000;
    end else if (hold_src) begin
      hold_cnt <= core_mem_pkg::HOLD_CYCLES;
    end else if (hold_cnt != 11'h000) begin
      hold_cnt <= hold_cnt - 11'h001;
    end
  end

  // Output flop: any source or pending hold keeps reset low
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      core_rst_b <= 1'b0;
    end else begin
      core_rst_b <= pin_sync[1] & ~any_src & (hold_cnt == 11'h000);
    end
  end

  AST_HOLD_START: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(hold_src) |-> hold_cnt == core_mem_pkg::HOLD_CYCLES ##1 !core_rst_b [*8])
    else $error("hold-off did not start at full count");

  AST_HOLD_KEEP: assert property (@(posedge mclk) disable iff (!rst_b)
    (hold_cnt > 11'h001) |=> !core_rst_b)
    else $error("core reset released during hold-off");

endmodule : core_reset_gen

// [hw/core_mem_reset.sv]
// Core memory paths, pointer and page registers, and reset gathering
// Function
// - Async pin reset accepted and synchronised
// - Pin reset clears nearly all registers
// - Power-on and converter resets held 1024 clocks
// - Brown-out also resets the device
// - Converter threshold and watchdog are reset sources
// - One instruction cycle takes four clocks
// - Program and data spaces stay separate
// - Four banks of eight working registers
// - 128-byte internal, 2048-byte external RAM
// - External accesses reach only on-chip block
// - Index register moves address internal RAM indirectly
// - Direct addressing also reaches special registers
// - Two 16-bit pointers from byte pairs
// - Pointer move uses selected pointer address
// - Index move address is page then index
// - Code fetch at accumulator plus pointer or counter
// - Moves never write program memory
// - Stretch field lengthens external access, resets 001
// - Extra debug trap instruction supported
// - Select 0 first pointer, 1 second
// - Bank field picks active bank address range
// - Stack pointer grows on push, shrinks on pop
module core_mem_reset (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic por_req,
  input wire logic bod_req,
  input wire logic wdt_req,
  input wire logic adc_req,
  input wire logic req_valid,
  input core_mem_pkg::mem_req_t req,
  output logic req_ready,
  output core_mem_pkg::mem_rsp_t rsp,
  output logic [15:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [7:0] pmem_rdata,
  output logic [7:0] accumulator,
  output logic core_rst_b
);

  // ----------------------------------------
  // Reset gathering
  // ----------------------------------------
  core_reset_gen u_reset (
    .mclk(mclk),
    .rst_b(rst_b),
    .por_req(por_req),
    .bod_req(bod_req),
    .wdt_req(wdt_req),
    .adc_req(adc_req),
    .core_rst_b(core_rst_b)
  );

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] iram [0:core_mem_pkg::IRAM_BYTES-1]; // Banks live at the bottom
  logic [7:0] xram [0:core_mem_pkg::XRAM_BYTES-1]; // On-chip external data
  core_mem_pkg::access_state_t state; // Sequencer state
  core_mem_pkg::access_state_t next_state; // Sequencer next state
  core_mem_pkg::mem_req_t cur; // Operation in flight
  logic [2:0] stretch_cnt; // Stretch clocks already spent
  logic [3:0] lat; // Clocks since acceptance, checked only
  logic [7:0] stack_pointer;
  logic [7:0] first_pointer_low_byte;
  logic [7:0] first_pointer_high_byte;
  logic [7:0] second_pointer_low_byte;
  logic [7:0] second_pointer_high_byte;
  logic pointer_select_register; // Only the select bit is stored
  logic [7:0] external_page_register;
  logic [7:0] clock_control_register;
  logic [7:0] program_status_word; // Parity bit is recomputed on read

  // ----------------------------------------
  // Operation decode
  // ----------------------------------------
  wire accept = req_valid & req_ready;
  wire op_dir = (cur.op == core_mem_pkg::OP_DIR_RD) | (cur.op == core_mem_pkg::OP_DIR_WR);
  wire op_ind = (cur.op == core_mem_pkg::OP_IND_RD) | (cur.op == core_mem_pkg::OP_IND_WR);
  wire op_reg = (cur.op == core_mem_pkg::OP_REG_RD) | (cur.op == core_mem_pkg::OP_REG_WR);
  wire op_xdp = (cur.op == core_mem_pkg::OP_XDP_RD) | (cur.op == core_mem_pkg::OP_XDP_WR);
  wire op_xri = (cur.op == core_mem_pkg::OP_XRI_RD) | (cur.op == core_mem_pkg::OP_XRI_WR);
  wire op_code = (cur.op == core_mem_pkg::OP_CODE_DP) | (cur.op == core_mem_pkg::OP_CODE_PC);
  wire op_push = cur.op == core_mem_pkg::OP_PUSH;
  wire op_pop = cur.op == core_mem_pkg::OP_POP;
  wire op_x = op_xdp | op_xri;
  wire op_wr = (cur.op == core_mem_pkg::OP_DIR_WR) | (cur.op == core_mem_pkg::OP_IND_WR)
             | (cur.op == core_mem_pkg::OP_REG_WR) | (cur.op == core_mem_pkg::OP_XDP_WR)
             | (cur.op == core_mem_pkg::OP_XRI_WR) | op_push;
  wire op_quiet = op_wr | (cur.op >= core_mem_pkg::OP_TRAP); // Trap and spare codes read nothing
  wire finish = state == core_mem_pkg::ST_LAST;
  wire [2:0] stretch_field = clock_control_register[core_mem_pkg::STRETCH_MSB:0];
  wire stretching = op_x & (stretch_cnt != stretch_field);

  // ----------------------------------------
  // Address formation
  // ----------------------------------------
  wire [1:0] bank_select_field =
    program_status_word[core_mem_pkg::BANK_MSB:core_mem_pkg::BANK_LSB];
  // Only R0 and R1 may serve as index registers
  wire [6:0] ri_addr = {2'h0, bank_select_field, 3'h0} | {6'h00, cur.rn[0]};
  wire [6:0] rn_addr = {2'h0, bank_select_field, cur.rn};
  wire [7:0] ri_val = iram[ri_addr];
  wire [15:0] first_data_pointer = {first_pointer_high_byte, first_pointer_low_byte};
  wire [15:0] second_data_pointer = {second_pointer_high_byte, second_pointer_low_byte};
  wire [15:0] sel_pointer = pointer_select_register ? second_data_pointer
                                                    : first_data_pointer;
  wire [15:0] x_addr16 = op_xdp ? sel_pointer
                                : {external_page_register, ri_val};
  // Upper pointer bits are dropped: no off-chip data space exists
  wire [core_mem_pkg::XRAM_AW-1:0] x_addr = x_addr16[core_mem_pkg::XRAM_AW-1:0];
  wire [7:0] sp_up = stack_pointer + 8'h01;
  wire [7:0] sp_down = stack_pointer - 8'h01;
  // Indirect access only sees the 128-byte RAM, never the registers
  wire [6:0] i_addr = op_dir ? cur.addr[6:0]
                    : op_ind ? ri_val[6:0]
                    : op_reg ? rn_addr
                    : op_push ? sp_up[6:0]
                    : stack_pointer[6:0];
  wire sfr_hit = op_dir & cur.addr[7];
  wire [7:0] sfr_addr = cur.addr[7:0];
  // Code fetch address from the request as it is taken
  wire [15:0] code_base = (req.op == core_mem_pkg::OP_CODE_DP) ? sel_pointer : req.addr;
  wire [15:0] code_addr = code_base + {8'h00, accumulator};

  // ----------------------------------------
  // Special register read selection
  // ----------------------------------------
  wire [7:0] sfr_rdata =
      (sfr_addr == core_mem_pkg::ADDR_STACK_POINTER) ? stack_pointer
    : (sfr_addr == core_mem_pkg::ADDR_FIRST_LOW) ? first_pointer_low_byte
    : (sfr_addr == core_mem_pkg::ADDR_FIRST_HIGH) ? first_pointer_high_byte
    : (sfr_addr == core_mem_pkg::ADDR_SECOND_LOW) ? second_pointer_low_byte
    : (sfr_addr == core_mem_pkg::ADDR_SECOND_HIGH) ? second_pointer_high_byte
    : (sfr_addr == core_mem_pkg::ADDR_POINTER_SELECT) ? {7'h00, pointer_select_register}
    : (sfr_addr == core_mem_pkg::ADDR_CLOCK_CONTROL) ? clock_control_register
    : (sfr_addr == core_mem_pkg::ADDR_EXTERNAL_PAGE) ? external_page_register
    : (sfr_addr == core_mem_pkg::ADDR_STATUS_WORD) ? {program_status_word[7:1], ^accumulator}
    : (sfr_addr == core_mem_pkg::ADDR_ACCUMULATOR) ? accumulator
    : 8'h00;

  // Data returned when the access ends
  wire [7:0] rd_val = op_x ? xram[x_addr]
                    : op_code ? pmem_rdata
                    : sfr_hit ? sfr_rdata
                    : iram[i_addr];
  // Byte written: external moves always carry the accumulator
  wire [7:0] wr_val = op_x ? accumulator : cur.data;
  wire sfr_we = finish & sfr_hit & (cur.op == core_mem_pkg::OP_DIR_WR);
  wire iram_we = finish & op_wr & ~op_x & ~sfr_hit;
  wire xram_we = finish & op_wr & op_x;
  wire acc_load = finish & (op_code | (op_x & ~op_wr));

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Four clocks per access, held in the wait state while stretching
  always_comb begin
    next_state = state;
    case (state)
      core_mem_pkg::ST_IDLE: begin
        if (accept) begin
          next_state = core_mem_pkg::ST_FETCH;
        end
      end
      core_mem_pkg::ST_FETCH: begin
        next_state = core_mem_pkg::ST_ADDR;
      end
      core_mem_pkg::ST_ADDR: begin
        next_state = core_mem_pkg::ST_WAIT;
      end
      core_mem_pkg::ST_WAIT: begin
        if (!stretching) begin
          next_state = core_mem_pkg::ST_LAST;
        end
      end
      core_mem_pkg::ST_LAST: begin
        next_state = core_mem_pkg::ST_IDLE;
      end
      default: begin
        next_state = core_mem_pkg::ST_IDLE;
      end
    endcase
  end

  // State, request latch and stretch counter
  always_ff @(posedge mclk or negedge core_rst_b) begin
    if (!core_rst_b) begin
      state <= core_mem_pkg::ST_IDLE;
      cur <= '0;
      stretch_cnt <= 3'h0;
      req_ready <= 1'b1;
    end else begin
      state <= next_state;
      req_ready <= next_state == core_mem_pkg::ST_IDLE;
      if (accept) begin
        cur <= req;
        stretch_cnt <= 3'h0;
      end else if (state == core_mem_pkg::ST_WAIT && stretching) begin
        stretch_cnt <= stretch_cnt + 3'h1;
      end
    end
  end

  // Program memory read port; no write path exists at all
  always_ff @(posedge mclk or negedge core_rst_b) begin
    if (!core_rst_b) begin
      pmem_addr <= 16'h0000;
      pmem_rd <= 1'b0;
    end else if (accept) begin
      pmem_addr <= code_addr;
      pmem_rd <= (req.op == core_mem_pkg::OP_CODE_DP) | (req.op == core_mem_pkg::OP_CODE_PC);
    end else if (finish) begin
      pmem_rd <= 1'b0;
    end
  end

  // Answer, one-cycle done pulse
  always_ff @(posedge mclk or negedge core_rst_b) begin
    if (!core_rst_b) begin
      rsp <= '0;
    end else begin
      rsp.done <= finish;
      rsp.trap <= finish & (cur.op == core_mem_pkg::OP_TRAP);
      if (finish) begin
        rsp.rdata <= op_quiet ? 8'h00 : rd_val;
      end
    end
  end

  // ----------------------------------------
  // Registers written by direct moves
  // ----------------------------------------
  always_ff @(posedge mclk or negedge core_rst_b) begin
    if (!core_rst_b) begin
      first_pointer_low_byte <= core_mem_pkg::BYTE_RESET;
      first_pointer_high_byte <= core_mem_pkg::BYTE_RESET;
      second_pointer_low_byte <= core_mem_pkg::BYTE_RESET;
      second_pointer_high_byte <= core_mem_pkg::BYTE_RESET;
      pointer_select_register <= 1'b0;
      external_page_register <= core_mem_pkg::BYTE_RESET;
      clock_control_register <= core_mem_pkg::CLOCK_CONTROL_RESET;
      program_status_word <= core_mem_pkg::BYTE_RESET;
    end else if (sfr_we) begin
      case (sfr_addr)
        core_mem_pkg::ADDR_FIRST_LOW: first_pointer_low_byte <= cur.data;
        core_mem_pkg::ADDR_FIRST_HIGH: first_pointer_high_byte <= cur.data;
        core_mem_pkg::ADDR_SECOND_LOW: second_pointer_low_byte <= cur.data;
        core_mem_pkg::ADDR_SECOND_HIGH: second_pointer_high_byte <= cur.data;
        core_mem_pkg::ADDR_POINTER_SELECT: pointer_select_register <= cur.data[0];
        core_mem_pkg::ADDR_EXTERNAL_PAGE: external_page_register <= cur.data;
        core_mem_pkg::ADDR_CLOCK_CONTROL: clock_control_register <= cur.data;
        core_mem_pkg::ADDR_STATUS_WORD: program_status_word <= cur.data;
        default: begin
        end
      endcase
    end
  end

  // Stack pointer moves up before a push, down after a pop
  always_ff @(posedge mclk or negedge core_rst_b) begin
    if (!core_rst_b) begin
      stack_pointer <= core_mem_pkg::STACK_POINTER_RESET;
    end else if (finish && op_push) begin
      stack_pointer <= sp_up;
    end else if (finish && op_pop) begin
      stack_pointer <= sp_down;
    end else if (sfr_we && sfr_addr == core_mem_pkg::ADDR_STACK_POINTER) begin
      stack_pointer <= cur.data;
    end
  end

  // Accumulator loads from external and code reads, or direct writes
  always_ff @(posedge mclk or negedge core_rst_b) begin
    if (!core_rst_b) begin
      accumulator <= core_mem_pkg::BYTE_RESET;
    end else if (acc_load) begin
      accumulator <= rd_val;
    end else if (sfr_we && sfr_addr == core_mem_pkg::ADDR_ACCUMULATOR) begin
      accumulator <= cur.data;
    end
  end

  // RAM contents survive reset; they are not cleared
  always_ff @(posedge mclk) begin
    if (iram_we) begin
      iram[i_addr] <= wr_val;
    end
    if (xram_we) begin
      xram[x_addr] <= wr_val;
    end
  end

  // Clocks since acceptance, for the timing checks only
  always_ff @(posedge mclk or negedge core_rst_b) begin
    if (!core_rst_b) begin
      lat <= 4'h0;
    end else if (accept) begin
      lat <= 4'h1;
    end else if (state != core_mem_pkg::ST_IDLE) begin
      lat <= lat + 4'h1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_CYCLE_LEN: assert property (@(posedge mclk) disable iff (!core_rst_b)
    finish |-> lat == core_mem_pkg::CYCLE_CLOCKS + (op_x ? {1'b0, stretch_field} : 4'h0))
    else $error("access length wrong");

  AST_PLAIN_FOUR: assert property (@(posedge mclk) disable iff (!core_rst_b)
    (accept && req.op == core_mem_pkg::OP_DIR_RD) |-> ##1 !rsp.done [*4] ##1 rsp.done)
    else $error("plain access not four clocks");

  AST_STRETCH_RST: assert property (@(posedge mclk) disable iff (!core_rst_b)
    !$past(core_rst_b) |-> stretch_field == 3'h1)
    else $error("stretch field reset wrong");

  AST_BANK_MAP: assert property (@(posedge mclk) disable iff (!core_rst_b)
    (finish && op_reg) |-> i_addr[4:3] == program_status_word[4:3] && i_addr[6:5] == 2'h0)
    else $error("register bank mapping wrong");

  AST_PTR_SEL: assert property (@(posedge mclk) disable iff (!core_rst_b)
    (finish && op_xdp) |-> x_addr == (pointer_select_register ? second_data_pointer[10:0]
                                                             : first_data_pointer[10:0]))
    else $error("pointer select wrong");

  AST_PAGE_ADDR: assert property (@(posedge mclk) disable iff (!core_rst_b)
    (finish && op_xri) |-> x_addr[7:0] == ri_val && x_addr[10:8] == external_page_register[2:0])
    else $error("page address wrong");

  AST_PUSH: assert property (@(posedge mclk) disable iff (!core_rst_b)
    (accept && req.op == core_mem_pkg::OP_PUSH)
      |-> ##5 stack_pointer == $past(stack_pointer, 5) + 8'h01)
    else $error("push did not raise stack pointer");

  AST_POP: assert property (@(posedge mclk) disable iff (!core_rst_b)
    (accept && req.op == core_mem_pkg::OP_POP)
      |-> ##5 stack_pointer == $past(stack_pointer, 5) - 8'h01)
    else $error("pop did not lower stack pointer");

  AST_CODE_ADDR: assert property (@(posedge mclk) disable iff (!core_rst_b)
    (accept && req.op == core_mem_pkg::OP_CODE_PC)
      |=> pmem_rd && pmem_addr == $past(req.addr) + {8'h00, $past(accumulator)})
    else $error("code fetch address wrong");

endmodule : core_mem_reset

// [tb/prog_flash_model.sv]
// Behavioural program flash model answering code fetches of the core
module prog_flash_model (
  input wire logic mclk,
  input wire logic [15:0] pmem_addr,
  input wire logic pmem_rd,
  output logic [7:0] pmem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] spin = 8'h00; // Filler that changes each cycle, so a late sample never matches
  // Filler counter runs on every clock
  always @(posedge mclk) spin <= spin + 8'h3B;
  // Read only: there is no write port, so a move can never alter code
  assign pmem_rdata = pmem_rd ? (pmem_addr[7:0] ^ pmem_addr[15:8]) : ~spin;
endmodule : prog_flash_model

// [tb/mcu_core_memory_reset_tb_top.sv]
// Self-checking bench for the core memory and reset block
module mcu_core_memory_reset_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    $display("MISMATCH %s exp %h got %h", nm, e, g); fails++; end end
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic mclk = 1'b0;
  logic rst_b = 1'b0; // Pin reset, held low at start
  logic por_req = 1'b0, bod_req = 1'b0, wdt_req = 1'b0, adc_req = 1'b0;
  logic req_valid = 1'b0;
  core_mem_pkg::mem_req_t req = '0;
  logic req_ready, pmem_rd, core_rst_b;
  core_mem_pkg::mem_rsp_t rsp;
  logic [15:0] pmem_addr;
  logic [7:0] pmem_rdata, accumulator;
  int fails = 0, samples_checked = 0;
  // Clock at 4 ns period
  always #2 mclk = ~mclk;
  core_mem_reset i_core_mem_reset (.mclk, .rst_b, .por_req, .bod_req, .wdt_req, .adc_req,
    .req_valid, .req, .req_ready, .rsp, .pmem_addr, .pmem_rd, .pmem_rdata, .accumulator,
    .core_rst_b);
  prog_flash_model i_prog_flash_model (.mclk, .pmem_addr, .pmem_rd, .pmem_rdata);
  // ----------------------------------------
  // Table of ordinary operations
  // ----------------------------------------
  typedef struct {logic [3:0] op; logic [15:0] a; logic [2:0] rn;
    logic [7:0] d; logic [7:0] e; int lat;} row_t;
  row_t rows[] = '{
    '{4'h0, 16'h8E, 3'h0, 8'h0, 8'h1, 4}, '{4'h1, 16'h8E, 3'h0, 8'h0, 8'h0, 4},
    '{4'h1, 16'h05, 3'h0, 8'hA5, 8'h0, 4}, '{4'h0, 16'h05, 3'h0, 8'h0, 8'hA5, 4},
    '{4'h1, 16'hD0, 3'h0, 8'h18, 8'h0, 4}, '{4'h5, 16'h0, 3'h2, 8'h3C, 8'h0, 4},
    '{4'h0, 16'h1A, 3'h0, 8'h0, 8'h3C, 4}, '{4'h5, 16'h0, 3'h1, 8'h10, 8'h0, 4},
    '{4'h3, 16'h0, 3'h1, 8'h77, 8'h0, 4}, '{4'h0, 16'h10, 3'h0, 8'h0, 8'h77, 4},
    '{4'h2, 16'h0, 3'h1, 8'h0, 8'h77, 4}, '{4'h4, 16'h0, 3'h2, 8'h0, 8'h3C, 4},
    '{4'h1, 16'h82, 3'h0, 8'h10, 8'h0, 4}, '{4'h1, 16'h83, 3'h0, 8'hFA, 8'h0, 4},
    '{4'h1, 16'h84, 3'h0, 8'h20, 8'h0, 4}, '{4'h1, 16'h85, 3'h0, 8'h03, 8'h0, 4},
    '{4'h0, 16'h82, 3'h0, 8'h0, 8'h10, 4}, '{4'h1, 16'hE0, 3'h0, 8'h99, 8'h0, 4},
    '{4'h7, 16'h0, 3'h0, 8'h0, 8'h0, 4}, '{4'h1, 16'h86, 3'h0, 8'h01, 8'h0, 4},
    '{4'h1, 16'hE0, 3'h0, 8'h66, 8'h0, 4}, '{4'h7, 16'h0, 3'h0, 8'h0, 8'h0, 4},
    '{4'h6, 16'h0, 3'h0, 8'h0, 8'h66, 4}, '{4'h1, 16'h86, 3'h0, 8'h0, 8'h0, 4},
    '{4'h6, 16'h0, 3'h0, 8'h0, 8'h99, 4}, '{4'h1, 16'h92, 3'h0, 8'h02, 8'h0, 4},
    '{4'h8, 16'h0, 3'h1, 8'h0, 8'h99, 4}, '{4'hA, 16'h0, 3'h0, 8'h0, 8'h53, 4},
    '{4'hB, 16'h1234, 3'h0, 8'h0, 8'h95, 4}, '{4'hC, 16'h0, 3'h0, 8'h55, 8'h0, 4},
    '{4'h0, 16'h81, 3'h0, 8'h0, 8'h01, 4}, '{4'hD, 16'h0, 3'h0, 8'h0, 8'h55, 4},
    '{4'h0, 16'h81, 3'h0, 8'h0, 8'h00, 4}, '{4'h1, 16'h8E, 3'h0, 8'h07, 8'h0, 4},
    '{4'h6, 16'h0, 3'h0, 8'h0, 8'h99, 11}, '{4'hF, 16'h0, 3'h0, 8'h0, 8'h0, 4}};
  // ----------------------------------------
  // Bus task and closing
  // ----------------------------------------
  // One request, held for one clock and checked taken, then wait for done under a bound
  task automatic run(input logic [3:0] op, input logic [15:0] a, input logic [2:0] r,
      input logic [7:0] d, output logic [7:0] got, output int lat, output logic trp);
    @(negedge mclk);
    req_valid = 1'b1;
    req = '{op: core_mem_pkg::mem_op_t'(op), addr: a, rn: r, data: d};
    @(posedge mclk);
    @(negedge mclk);
    `CHK("busy", 1'b0, req_ready)
    req_valid = 1'b0;
    lat = 0;
    do begin @(posedge mclk); #1; lat++; end while (rsp.done !== 1'b1 && lat < 40);
    got = rsp.rdata;
    trp = rsp.trap;
  endtask : run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // Watchdog well beyond the two long hold-offs plus the table
  initial begin
    #60000;
    fails++;
    finish_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] got;
    logic trp;
    int lat, n;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    repeat (5) @(posedge mclk);
    // Ordinary rows: stretch starts at one, then fastest, then seven
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].a, rows[i].rn, rows[i].d, got, lat, trp);
      `CHK("rdata", rows[i].e, got)
      `CHK("latency", rows[i].lat, lat)
    end
    run(4'hE, 16'h0, 3'h0, 8'h0, got, lat, trp);
    `CHK("trap", 1'b1, trp)
    // Pin reset mid-cycle: falls at once, rises on the third edge
    @(negedge mclk);
    #0.5 rst_b = 1'b0;
    #0.5 `CHK("async", 1'b0, core_rst_b)
    repeat (2) @(negedge mclk);
    #0.7 rst_b = 1'b1;
    repeat (2) @(posedge mclk);
    #1 `CHK("sync2", 1'b0, core_rst_b)
    @(posedge mclk);
    #1 `CHK("sync3", 1'b1, core_rst_b)
    `CHK("acc_clr", 8'h00, accumulator)
    run(4'h0, 16'h82, 3'h0, 8'h0, got, lat, trp);
    `CHK("ptr_lo_clr", 8'h00, got)
    run(4'h0, 16'h8E, 3'h0, 8'h0, got, lat, trp);
    `CHK("stretch_rst", 8'h01, got)
    // Power-on then converter request: long hold-off after release
    for (int k = 0; k < 2; k++) begin
      @(negedge mclk);
      if (k == 0) por_req = 1'b1;
      else adc_req = 1'b1;
      repeat (6) @(negedge mclk);
      `CHK("src_rst", 1'b0, core_rst_b)
      por_req = 1'b0;
      adc_req = 1'b0;
      n = 0;
      while (core_rst_b !== 1'b1 && n < 1100) begin @(posedge mclk); #1; n++; end
      `CHK("hold", 1'b1, (n >= 1024 && n <= 1030))
    end
    // Brown-out then watchdog: reset only while the request stands
    for (int k = 0; k < 2; k++) begin
      @(negedge mclk);
      if (k == 0) bod_req = 1'b1;
      else wdt_req = 1'b1;
      repeat (5) @(negedge mclk);
      `CHK("level_rst", 1'b0, core_rst_b)
      bod_req = 1'b0;
      wdt_req = 1'b0;
      repeat (6) @(negedge mclk);
      `CHK("release", 1'b1, core_rst_b)
    end
    finish_test();
  end
endmodule : mcu_core_memory_reset_tb_top
